// ===== hdl/ppfm_pkg.sv
// package for the port pin function mux: register map, field positions, resets
// assumes a single 100 MHz clock domain and a plain strobe register port
package ppfm_pkg;

  // ==========================================================
  // register offsets (byte addresses, word aligned)
  localparam logic [7:0] ADDR_PA_OUT     = 8'h00;
  localparam logic [7:0] ADDR_PA_DIR     = 8'h04;
  localparam logic [7:0] ADDR_PA_PULLUP  = 8'h08;
  localparam logic [7:0] ADDR_PA_INEN    = 8'h0c;
  localparam logic [7:0] ADDR_PA_IN      = 8'h10;
  localparam logic [7:0] ADDR_PB_OUT     = 8'h14;
  localparam logic [7:0] ADDR_PB_DIR     = 8'h18;
  localparam logic [7:0] ADDR_PB_PULLUP  = 8'h1c;
  localparam logic [7:0] ADDR_PB_PULLDN  = 8'h20;
  localparam logic [7:0] ADDR_PB_INEN    = 8'h24;
  localparam logic [7:0] ADDR_PB_IN      = 8'h28;
  localparam logic [7:0] ADDR_ALT_SEL    = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_CFG    = 8'h30;
  localparam logic [7:0] ADDR_ANA_SEL    = 8'h34;

  // ==========================================================
  // covered pins and pull-down capable pins
  localparam logic [7:0] PA_MASK   = 8'h09;
  localparam logic [7:0] PB_MASK   = 8'hfc;
  localparam logic [7:0] PB_PD_MSK = 8'h48;

  // ==========================================================
  // alternate select fields
  localparam int ALT_T2_PA3 = 0;
  localparam int ALT_T2_PB4 = 1;
  localparam int ALT_T2_PB2 = 2;
  localparam int ALT_T3_PB7 = 3;
  localparam int ALT_T3_PB6 = 4;
  localparam int ALT_T3_PB5 = 5;
  localparam int ALT_CMP_PA0 = 6;

  // irq config: bit0 source (0 pa0, 1 pb5), bits2:1 edge mode
  localparam int IRQ_SRC_BIT = 0;
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;

  // analog selector codes; 4-bit adc channel, 3-bit comparator source
  localparam logic [3:0] ADC_CH_PA3 = 4'h8;
  localparam logic [3:0] ADC_CH_PA0 = 4'ha;
  localparam logic [2:0] CMP_SRC_PA3 = 3'h0;
  localparam logic [2:0] CMP_SRC_PB6 = 3'h4;
  localparam logic [2:0] CMP_SRC_PB7 = 3'h5;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_INEN = 8'hff;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] pd;
  } ppfm_pad_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppfm_bus_t;

endpackage : ppfm_pkg

// ===== hdl/ppfm_top.sv
// port pin function mux for port a bits 0,3 and port b bits 2..7
// assumes synchronous pad inputs and a master that never both-strobes
// Functional notes
// - each pin is software input or push-pull output with optional pull-up
// - port b bits 6 and 3 also offer an independent pull-down
// - clearing port a enable bit 3 kills its input and wake-up
// - clearing port b enable bits 2..7 kills input and wake-up
// - clearing port a enable bit 0 blocks wake-up from that pin
// - port a bit 0 feeds interrupt line zero, edge selectable
// - port b bit 5 is alternate source of line zero, same edges
// - timer two pwm routes to port a bit 3, port b bits 4 and 2
// - timer three pwm routes to port b bits 7, 6 and 5
// - port a bit 0 may drive the comparator result
// - comparator negative select 0,4,5 maps to pa3, pb6, pb7
// - adc channel 8 pa3, 10 pa0, 2..7 to port b bits
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ppfm_top (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire ppfm_pkg::ppfm_bus_t  bus,
  output var  logic [7:0]           rdata,
  input  wire logic [7:0]           pa_pad_in,
  input  wire logic [7:0]           pb_pad_in,
  output var  ppfm_pkg::ppfm_pad_t  pa_pad,
  output var  ppfm_pkg::ppfm_pad_t  pb_pad,
  input  wire logic                 timer_two_pwm_out,
  input  wire logic                 timer_three_pwm_out,
  input  wire logic                 comparator_result_out,
  output var  logic                 ext_irq_line_zero,
  output var  logic                 wake_req,
  output var  logic                 adc_pin_sel,
  output var  logic [7:0]           adc_pa_conn,
  output var  logic [7:0]           adc_pb_conn,
  output var  logic [7:0]           cmp_pa_conn,
  output var  logic [7:0]           cmp_pb_conn
);

  // ==========================================================
  // registers
  logic [7:0] pa_out_q, pa_dir_q, pa_pu_q, pa_inen_q;
  logic [7:0] pb_out_q, pb_dir_q, pb_pu_q, pb_pd_q, pb_inen_q;
  logic [7:0] alt_q;
  logic [2:0] irq_cfg_q;
  logic [7:0] ana_q;
  logic [7:0] pa_in_q, pb_in_q;
  logic [7:0] pa_in_d, pb_in_d;
  logic       irq_src_q;
  logic       irq_src_d;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pa_out_q  <= ppfm_pkg::RST_ZERO;
      pa_dir_q  <= ppfm_pkg::RST_ZERO;
      pa_pu_q   <= ppfm_pkg::RST_ZERO;
      pa_inen_q <= ppfm_pkg::RST_INEN & ppfm_pkg::PA_MASK;
      pb_out_q  <= ppfm_pkg::RST_ZERO;
      pb_dir_q  <= ppfm_pkg::RST_ZERO;
      pb_pu_q   <= ppfm_pkg::RST_ZERO;
      pb_pd_q   <= ppfm_pkg::RST_ZERO;
      pb_inen_q <= ppfm_pkg::RST_INEN & ppfm_pkg::PB_MASK;
      alt_q     <= ppfm_pkg::RST_ZERO;
      irq_cfg_q <= 3'h0;
      ana_q     <= ppfm_pkg::RST_ZERO;
    end
    else if (bus.wr)
    begin
      // unmapped writes are dropped; uncovered bits stay zero
      unique case (bus.addr)
        ppfm_pkg::ADDR_PA_OUT:    pa_out_q  <= bus.wdata & ppfm_pkg::PA_MASK;
        ppfm_pkg::ADDR_PA_DIR:    pa_dir_q  <= bus.wdata & ppfm_pkg::PA_MASK;
        ppfm_pkg::ADDR_PA_PULLUP: pa_pu_q   <= bus.wdata & ppfm_pkg::PA_MASK;
        ppfm_pkg::ADDR_PA_INEN:   pa_inen_q <= bus.wdata & ppfm_pkg::PA_MASK;
        ppfm_pkg::ADDR_PB_OUT:    pb_out_q  <= bus.wdata & ppfm_pkg::PB_MASK;
        ppfm_pkg::ADDR_PB_DIR:    pb_dir_q  <= bus.wdata & ppfm_pkg::PB_MASK;
        ppfm_pkg::ADDR_PB_PULLUP: pb_pu_q   <= bus.wdata & ppfm_pkg::PB_MASK;
        ppfm_pkg::ADDR_PB_PULLDN: pb_pd_q   <= bus.wdata & ppfm_pkg::PB_PD_MSK;
        ppfm_pkg::ADDR_PB_INEN:   pb_inen_q <= bus.wdata & ppfm_pkg::PB_MASK;
        ppfm_pkg::ADDR_ALT_SEL:   alt_q     <= {1'b0, bus.wdata[6:0]};
        ppfm_pkg::ADDR_IRQ_CFG:   irq_cfg_q <= bus.wdata[2:0];
        ppfm_pkg::ADDR_ANA_SEL:   ana_q     <= bus.wdata;
        default:                  ;
      endcase
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        ppfm_pkg::ADDR_PA_OUT:    rdata <= pa_out_q;
        ppfm_pkg::ADDR_PA_DIR:    rdata <= pa_dir_q;
        ppfm_pkg::ADDR_PA_PULLUP: rdata <= pa_pu_q;
        ppfm_pkg::ADDR_PA_INEN:   rdata <= pa_inen_q;
        ppfm_pkg::ADDR_PA_IN:     rdata <= pa_in_q;
        ppfm_pkg::ADDR_PB_OUT:    rdata <= pb_out_q;
        ppfm_pkg::ADDR_PB_DIR:    rdata <= pb_dir_q;
        ppfm_pkg::ADDR_PB_PULLUP: rdata <= pb_pu_q;
        ppfm_pkg::ADDR_PB_PULLDN: rdata <= pb_pd_q;
        ppfm_pkg::ADDR_PB_INEN:   rdata <= pb_inen_q;
        ppfm_pkg::ADDR_PB_IN:     rdata <= pb_in_q;
        ppfm_pkg::ADDR_ALT_SEL:   rdata <= alt_q;
        ppfm_pkg::ADDR_IRQ_CFG:   rdata <= {5'h00, irq_cfg_q};
        ppfm_pkg::ADDR_ANA_SEL:   rdata <= ana_q;
        default:                  rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // ==========================================================
  // gated input buffer
  // gate with enables
  assign pa_in_d = pa_pad_in & pa_inen_q & ppfm_pkg::PA_MASK;
  assign pb_in_d = pb_pad_in & pb_inen_q & ppfm_pkg::PB_MASK;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pa_in_q <= 8'h00;
      pb_in_q <= 8'h00;
    end
    else
    begin
      pa_in_q <= pa_in_d;
      pb_in_q <= pb_in_d;
    end
  end

  // ==========================================================
  // wake-up on any toggle of an enabled pin
  // disabled pins read zero both cycles, so no toggle
  always_ff @(posedge clk)
  begin
    if (srst)
      wake_req <= 1'b0;
    else
      wake_req <= |((pa_in_d ^ pa_in_q) | (pb_in_d ^ pb_in_q));
  end

  // ==========================================================
  // external interrupt line zero
  // source select, then edge detect
  assign irq_src_d = irq_cfg_q[ppfm_pkg::IRQ_SRC_BIT] ? pb_in_d[5] : pa_in_d[0];

  always_ff @(posedge clk)
  begin
    if (srst)
      irq_src_q <= 1'b0;
    else
      irq_src_q <= irq_src_d;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ext_irq_line_zero <= 1'b0;
    else
    begin
      // switching source may give one edge; software should mask first
      unique case (irq_cfg_q[2:1])
        ppfm_pkg::EDGE_RISE: ext_irq_line_zero <= irq_src_d & ~irq_src_q;
        ppfm_pkg::EDGE_FALL: ext_irq_line_zero <= ~irq_src_d & irq_src_q;
        default:             ext_irq_line_zero <= irq_src_d ^ irq_src_q;
      endcase
    end
  end

  // ==========================================================
  // pad drivers with alternate outputs
  logic [7:0] pa_alt_en, pb_alt_en, pa_alt_val, pb_alt_val;

  always_comb
  begin
    pa_alt_en  = 8'h00;
    pb_alt_en  = 8'h00;
    pa_alt_val = 8'h00;
    pb_alt_val = 8'h00;
    pa_alt_en[3]  = alt_q[ppfm_pkg::ALT_T2_PA3];
    pa_alt_val[3] = timer_two_pwm_out;
    pb_alt_en[4]  = alt_q[ppfm_pkg::ALT_T2_PB4];
    pb_alt_val[4] = timer_two_pwm_out;
    pb_alt_en[2]  = alt_q[ppfm_pkg::ALT_T2_PB2];
    pb_alt_val[2] = timer_two_pwm_out;
    pb_alt_en[7]  = alt_q[ppfm_pkg::ALT_T3_PB7];
    pb_alt_val[7] = timer_three_pwm_out;
    pb_alt_en[6]  = alt_q[ppfm_pkg::ALT_T3_PB6];
    pb_alt_val[6] = timer_three_pwm_out;
    pb_alt_en[5]  = alt_q[ppfm_pkg::ALT_T3_PB5];
    pb_alt_val[5] = timer_three_pwm_out;
    pa_alt_en[0]  = alt_q[ppfm_pkg::ALT_CMP_PA0];
    pa_alt_val[0] = comparator_result_out;
  end

  // alternate functions override the gpio driver
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pa_pad <= '0;
      pb_pad <= '0;
    end
    else
    begin
      pa_pad.out <= (pa_alt_en & pa_alt_val) | (~pa_alt_en & pa_out_q);
      pa_pad.oe  <= pa_alt_en | pa_dir_q;
      pa_pad.pu  <= pa_pu_q & ~(pa_alt_en | pa_dir_q);
      pa_pad.pd  <= 8'h00;
      pb_pad.out <= (pb_alt_en & pb_alt_val) | (~pb_alt_en & pb_out_q);
      pb_pad.oe  <= pb_alt_en | pb_dir_q;
      pb_pad.pu  <= pb_pu_q & ~(pb_alt_en | pb_dir_q);
      pb_pad.pd  <= pb_pd_q & ~(pb_alt_en | pb_dir_q);
    end
  end

  // ==========================================================
  // analog switch select: ana_q[3:0] adc channel, [6:4] cmp source, [7] adc on
  // software should clear input enable for pins selected here
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      adc_pin_sel <= 1'b0;
      adc_pa_conn <= 8'h00;
      adc_pb_conn <= 8'h00;
      cmp_pa_conn <= 8'h00;
      cmp_pb_conn <= 8'h00;
    end
    else
    begin
      adc_pin_sel    <= ana_q[7];
      adc_pa_conn    <= 8'h00;
      adc_pb_conn    <= 8'h00;
      adc_pa_conn[3] <= ana_q[7] && ana_q[3:0] == ppfm_pkg::ADC_CH_PA3;
      adc_pa_conn[0] <= ana_q[7] && ana_q[3:0] == ppfm_pkg::ADC_CH_PA0;
      for (int i = 2; i < 8; i++)
        adc_pb_conn[i] <= ana_q[7] && ana_q[3:0] == 4'(i);
      cmp_pa_conn    <= 8'h00;
      cmp_pb_conn    <= 8'h00;
      cmp_pa_conn[3] <= ana_q[6:4] == ppfm_pkg::CMP_SRC_PA3;
      cmp_pb_conn[6] <= ana_q[6:4] == ppfm_pkg::CMP_SRC_PB6;
      cmp_pb_conn[7] <= ana_q[6:4] == ppfm_pkg::CMP_SRC_PB7;
    end
  end

  // ==========================================================
  // checks
  // gated input reads low
  gated_low_a: assert property (@(posedge clk) disable iff (srst)
    !pa_inen_q[3] |=> !pa_in_q[3]) else $error("disabled pa3 input not low");
  pb_gate_a: assert property (@(posedge clk) disable iff (srst)
    (pb_inen_q == 8'h00) |=> (pb_in_q == 8'h00)) else $error("pb input not gated");
  pa0_wake_a: assert property (@(posedge clk) disable iff (srst)
    (!pa_inen_q[0] && $stable(pa_inen_q) && pb_in_d == pb_in_q && pa_in_d[3] == pa_in_q[3])
    |=> !wake_req) else $error("wake from disabled pin");
  rise_irq_a: assert property (@(posedge clk) disable iff (srst)
    (irq_cfg_q == 3'h2 && $rose(pa_in_d[0])) |=> ext_irq_line_zero)
    else $error("missed rising edge");
  alt_src_a: assert property (@(posedge clk) disable iff (srst)
    (irq_cfg_q == 3'h1 && pb_in_d[5] != pb_in_q[5]) |=> ext_irq_line_zero)
    else $error("alt source edge missed");
  t2_route_a: assert property (@(posedge clk) disable iff (srst)
    alt_q[ppfm_pkg::ALT_T2_PB4] |=> (pb_pad.oe[4] && pb_pad.out[4] == $past(timer_two_pwm_out)))
    else $error("timer two not on pb4");
  t3_route_a: assert property (@(posedge clk) disable iff (srst)
    alt_q[ppfm_pkg::ALT_T3_PB7] |=> (pb_pad.out[7] == $past(timer_three_pwm_out)))
    else $error("timer three not on pb7");
  cmp_out_a: assert property (@(posedge clk) disable iff (srst)
    alt_q[ppfm_pkg::ALT_CMP_PA0] |=> (pa_pad.out[0] == $past(comparator_result_out)))
    else $error("comparator not on pa0");
  cmp_map_a: assert property (@(posedge clk) disable iff (srst)
    (ana_q[6:4] == 3'h4) |=> (cmp_pb_conn == 8'h40 && cmp_pa_conn == 8'h00))
    else $error("comparator map wrong");
  adc_map_a: assert property (@(posedge clk) disable iff (srst)
    (ana_q == 8'h8a) |=> (adc_pa_conn == 8'h01 && adc_pb_conn == 8'h00))
    else $error("adc channel 10 map wrong");
  pulldn_a: assert property (@(posedge clk) disable iff (srst)
    (pb_pad.pd & ~ppfm_pkg::PB_PD_MSK) == 8'h00) else $error("pull-down on wrong pin");


  // ==========================================================
  // pad, wake, irq and map checks beyond the basic set
  // pull-up off while driving
  pu_drive_off_a: assert property (@(posedge clk) disable iff (srst)
    ((pa_pad.pu & pa_pad.oe) == 8'h00 && (pb_pad.pu & pb_pad.oe) == 8'h00))
    else $error("pull-up on while driving");
  gpio_drive_a: assert property (@(posedge clk) disable iff (srst)
    (!alt_q[ppfm_pkg::ALT_T2_PB4] && pb_dir_q[4]) |=> (pb_pad.oe[4] && pb_pad.out[4] == $past(pb_out_q[4])))
    else $error("gpio drive on pb4 wrong");
  pd_drive_off_a: assert property (@(posedge clk) disable iff (srst)
    (pb_pad.pd & pb_pad.oe) == 8'h00) else $error("pull-down on while driving");
  pb_wake_off_a: assert property (@(posedge clk) disable iff (srst)
    (pb_inen_q == 8'h00 && $stable(pb_inen_q) && pa_in_d == pa_in_q) |=> !wake_req)
    else $error("wake from disabled port b");
  fall_irq_a: assert property (@(posedge clk) disable iff (srst)
    (irq_cfg_q == 3'h4 && $stable(irq_cfg_q) && $fell(pa_in_d[0])) |=> ext_irq_line_zero)
    else $error("missed falling edge");
  t2_pa3_a: assert property (@(posedge clk) disable iff (srst)
    alt_q[ppfm_pkg::ALT_T2_PA3] |=> (pa_pad.oe[3] && pa_pad.out[3] == $past(timer_two_pwm_out)))
    else $error("timer two not on pa3");
  adc_pb_map_a: assert property (@(posedge clk) disable iff (srst)
    (ana_q == 8'h85) |=> (adc_pb_conn == 8'h20 && adc_pa_conn == 8'h00))
    else $error("adc channel 5 map wrong");

  irq_alt_c: cover property (@(posedge clk) ext_irq_line_zero && irq_cfg_q[ppfm_pkg::IRQ_SRC_BIT]);
  adc_on_c: cover property (@(posedge clk) adc_pin_sel && adc_pb_conn != 8'h00);
  irq_seen_c: cover property (@(posedge clk) ext_irq_line_zero);
  wake_seen_c: cover property (@(posedge clk) wake_req);
  pwm_pa3_c: cover property (@(posedge clk) pa_pad.oe[3] && alt_q[ppfm_pkg::ALT_T2_PA3]);

endmodule // ppfm_top

`default_nettype wire

// ===== test/ppfm_periph_model.sv
// stand-in for the timer and comparator blocks feeding the pin mux
// assumes the bench picks the levels through lvl, one clock domain
`timescale 1ns/1ps
`default_nettype none

module ppfm_periph_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] lvl,
  output var  logic       timer_two_pwm_out,
  output var  logic       timer_three_pwm_out,
  output var  logic       comparator_result_out
);
  // ==========================================================
  // registered like real peripheral flops, low while in reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      timer_two_pwm_out     <= 1'b0;
      timer_three_pwm_out   <= 1'b0;
      comparator_result_out <= 1'b0;
    end
    else
    begin
      timer_two_pwm_out     <= lvl[0];
      timer_three_pwm_out   <= lvl[1];
      comparator_result_out <= lvl[2];
    end
  end
endmodule // ppfm_periph_model

`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the port pin function mux
// assumes the register map and field codes of ppfm_pkg
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, a); end end

module tb;
  logic                clk;
  logic                srst;
  ppfm_pkg::ppfm_bus_t bus;
  logic [7:0]          rdata;
  logic [7:0]          pa_in;
  logic [7:0]          pb_in;
  ppfm_pkg::ppfm_pad_t pa_pad;
  ppfm_pkg::ppfm_pad_t pb_pad;
  logic [2:0]          lvl;
  logic                t2, t3, cmp, irq, wake, adc_on;
  logic [7:0]          adc_pa, adc_pb, cmp_pa, cmp_pb;
  int                  n_fail, samples_checked, cycles, irq_n, wake_n;

  ppfm_periph_model i_ppfm_periph_model (.clk(clk), .srst(srst), .lvl(lvl), .timer_two_pwm_out(t2),
    .timer_three_pwm_out(t3), .comparator_result_out(cmp));

  ppfm_top i_ppfm_top (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .pa_pad_in(pa_in), .pb_pad_in(pb_in),
    .pa_pad(pa_pad), .pb_pad(pb_pad), .timer_two_pwm_out(t2), .timer_three_pwm_out(t3),
    .comparator_result_out(cmp), .ext_irq_line_zero(irq), .wake_req(wake), .adc_pin_sel(adc_on),
    .adc_pa_conn(adc_pa), .adc_pb_conn(adc_pb), .cmp_pa_conn(cmp_pa), .cmp_pb_conn(cmp_pb));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // pulse counters and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (!srst && irq === 1'b1) irq_n++;
    if (!srst && wake === 1'b1) wake_n++;
    if (cycles == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pulse(input logic on_a, input int b);
    @(posedge clk);
    if (on_a) pa_in[b] <= 1'b1; else pb_in[b] <= 1'b1;
    idle(3);
    if (on_a) pa_in[b] <= 1'b0; else pb_in[b] <= 1'b0;
    idle(3);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    `CHK("pa_pad", 32'h0, pa_pad)
    `CHK("pb_pad", 32'h0, pb_pad)
    rd(ppfm_pkg::ADDR_PA_INEN, d);
    `CHK("pa_inen", ppfm_pkg::PA_MASK, d & ppfm_pkg::PA_MASK)
    rd(ppfm_pkg::ADDR_PB_INEN, d);
    `CHK("pb_inen", ppfm_pkg::PB_MASK, d & ppfm_pkg::PB_MASK)
    rd(8'hfc, d);
    `CHK("unmapped", 8'h00, d)
  endtask

  task automatic t_gpio();
    logic [7:0] d;
    wr(ppfm_pkg::ADDR_PB_DIR, 8'hfc);
    wr(ppfm_pkg::ADDR_PB_OUT, 8'ha4);
    idle(3);
    `CHK("pb_oe", 8'hfc, pb_pad.oe & ppfm_pkg::PB_MASK)
    `CHK("pb_out", 8'ha4, pb_pad.out & ppfm_pkg::PB_MASK)
    wr(ppfm_pkg::ADDR_PB_DIR, 8'h00);
    wr(ppfm_pkg::ADDR_PB_PULLUP, 8'h94);
    pb_in <= 8'h28;
    idle(3);
    `CHK("pb_pu", 8'h94, pb_pad.pu & ppfm_pkg::PB_MASK)
    rd(ppfm_pkg::ADDR_PB_IN, d);
    `CHK("pb_in", 8'h28, d & ppfm_pkg::PB_MASK)
    pb_in <= 8'h00;
    wr(ppfm_pkg::ADDR_PB_PULLUP, 8'h00);
  endtask

  // pull-down only on bits 3 and 6
  task automatic t_pulldown();
    logic [7:0] d;
    wr(ppfm_pkg::ADDR_PB_PULLDN, 8'hff);
    idle(3);
    `CHK("pb_pd", ppfm_pkg::PB_PD_MSK, pb_pad.pd)
    `CHK("pb_pu_indep", 8'h00, pb_pad.pu)
    rd(ppfm_pkg::ADDR_PB_PULLDN, d);
    `CHK("pb_pd_rd", ppfm_pkg::PB_PD_MSK, d)
    wr(ppfm_pkg::ADDR_PB_PULLDN, 8'h00);
  endtask

  // disabled pins read low and make no pulses
  task automatic t_inen();
    logic [7:0] d;
    wr(ppfm_pkg::ADDR_PA_INEN, 8'h00);
    wr(ppfm_pkg::ADDR_PB_INEN, 8'h00);
    idle(3);
    wake_n = 0;
    irq_n = 0;
    for (int b = 2; b < 8; b++) pulse(1'b0, b);
    pulse(1'b1, 0);
    pulse(1'b1, 3);
    `CHK("wake_off", 0, wake_n)
    `CHK("irq_off", 0, irq_n)
    pb_in <= 8'hfc;
    idle(3);
    rd(ppfm_pkg::ADDR_PB_IN, d);
    `CHK("pb_in_off", 8'h00, d)
    pb_in <= 8'h00;
    wr(ppfm_pkg::ADDR_PA_INEN, 8'hff);
    wr(ppfm_pkg::ADDR_PB_INEN, 8'hff);
    idle(3);
    wake_n = 0;
    pulse(1'b0, 2);
    `CHK("wake_on", 2, wake_n)
  endtask

  // every edge mode on both sources
  task automatic t_irq();
    logic [1:0] modes [3];
    int         exp_n [3];
    modes = '{ppfm_pkg::EDGE_RISE, ppfm_pkg::EDGE_FALL, ppfm_pkg::EDGE_BOTH};
    exp_n = '{1, 1, 2};
    for (int s = 0; s < 2; s++)
    begin
      for (int m = 0; m < 3; m++)
      begin
        wr(ppfm_pkg::ADDR_IRQ_CFG, {5'h00, modes[m], s[0]});
        idle(3);
        irq_n = 0;
        pulse(s[0], s[0] ? 0 : 5);
        pulse(!s[0], s[0] ? 5 : 0);
        `CHK("irq_count", exp_n[m], irq_n)
      end
    end
  endtask

  // one source high at a time
  task automatic t_alt();
    logic [2:0] src [3];
    logic [7:0] pa_e [3];
    logic [7:0] pb_e [3];
    src = '{3'b001, 3'b010, 3'b100};
    pa_e = '{8'h08, 8'h00, 8'h01};
    pb_e = '{8'h14, 8'he0, 8'h00};
    wr(ppfm_pkg::ADDR_ALT_SEL, 8'h7f);
    for (int i = 0; i < 3; i++)
    begin
      lvl <= src[i];
      idle(4);
      `CHK("pa_alt_oe", 8'h09, pa_pad.oe & 8'h09)
      `CHK("pb_alt_oe", 8'hf4, pb_pad.oe & 8'hf4)
      `CHK("pa_alt_out", pa_e[i], pa_pad.out & 8'h09)
      `CHK("pb_alt_out", pb_e[i], pb_pad.out & 8'hf4)
    end
    wr(ppfm_pkg::ADDR_ALT_SEL, 8'h00);
  endtask

  task automatic t_analog();
    // software turns digital inputs off first
    wr(ppfm_pkg::ADDR_PA_INEN, 8'h00);
    wr(ppfm_pkg::ADDR_PB_INEN, 8'h00);
    for (int ch = 2; ch < 8; ch++)
    begin
      wr(ppfm_pkg::ADDR_ANA_SEL, 8'h80 | 8'(ch));
      idle(3);
      `CHK("adc_pb", 8'h01 << ch, adc_pb)
      `CHK("adc_pa", 8'h00, adc_pa)
      `CHK("adc_on", 1'b1, adc_on)
    end
    wr(ppfm_pkg::ADDR_ANA_SEL, {4'h8, ppfm_pkg::ADC_CH_PA3});
    idle(3);
    `CHK("adc_pa3", 8'h08, adc_pa)
    wr(ppfm_pkg::ADDR_ANA_SEL, {4'h8, ppfm_pkg::ADC_CH_PA0});
    idle(3);
    `CHK("adc_pa0", 8'h01, adc_pa)
    `CHK("adc_pb_off", 8'h00, adc_pb)
    wr(ppfm_pkg::ADDR_ANA_SEL, {1'b0, ppfm_pkg::CMP_SRC_PB6, 4'h0});
    idle(3);
    `CHK("cmp_pb6", 8'h40, cmp_pb)
    `CHK("adc_off", 1'b0, adc_on)
    wr(ppfm_pkg::ADDR_ANA_SEL, {1'b0, ppfm_pkg::CMP_SRC_PB7, 4'h0});
    idle(3);
    `CHK("cmp_pb7", 8'h80, cmp_pb)
    wr(ppfm_pkg::ADDR_ANA_SEL, {1'b0, ppfm_pkg::CMP_SRC_PA3, 4'h0});
    idle(3);
    `CHK("cmp_pa3", 8'h08, cmp_pa)
    `CHK("cmp_pb_off", 8'h00, cmp_pb)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    irq_n = 0;
    wake_n = 0;
    srst = 1'b1;
    bus = '0;
    pa_in = 8'h00;
    pb_in = 8'h00;
    lvl = 3'b000;
    idle(5);
    srst <= 1'b0;
    idle(1);
    t_reset();
    t_gpio();
    t_pulldown();
    t_inen();
    t_irq();
    t_alt();
    t_analog();
    tally_and_finish();
  end
endmodule // tb

`undef CHK
`default_nettype wire
